// ---- tcm_mode_config.sv ----
// Overview of operation
// - Channel-4 selection 00 in bits 9:8 makes channel 4 an output.
// - Channel-4 selection 01 takes input 4, 10 takes input 3.
// - Channel-4 selection 11 takes the internal trigger when selected.
// - Channel-4 selection writes are dropped while channel 4 is enabled.
// - Channel-3 selection 00 in bits 1:0 makes channel 3 an output.
// - Channel-3 selection 01 takes input 3, 10 takes input 4.
// - Channel-3 selection 11 takes the internal trigger when selected.
// - Channel-3 selection writes are dropped while channel 3 is enabled.
// - Channel-4 compare fields: clear 15, mode 14:12, preload 11, fast 10.
// - Channel-3 compare fields: clear 7, mode 6:4, preload 3, fast 2.
// - Capture fields: filter 15:12 and 7:4, prescaler 11:10 and 3:2.
// - Codes for both channels match those of channels 1 and 2.
// - Prescaler captures every 1, 2, 4 or 8 edges for codes 00 to 11.
// - A disabled channel holds its prescaler in reset.
// - Fast enable in a pulse-width mode turns a trigger edge into a match.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_mode_config (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic timer_input_3,
	input wire logic timer_input_4,
	input wire logic internal_trigger_signal,
	input wire logic trigger_source_internal,
	input wire logic ch3_enable,
	input wire logic ch4_enable,
	output tcm_pkg::tcm_sel_t ch3_direction_select,
	output tcm_pkg::tcm_sel_t ch4_direction_select,
	output logic ch3_is_output,
	output logic ch4_is_output,
	output logic ch3_ref_clear_enable,
	output logic ch4_ref_clear_enable,
	output tcm_pkg::tcm_mode_t ch3_compare_mode,
	output tcm_pkg::tcm_mode_t ch4_compare_mode,
	output logic ch3_preload_enable,
	output logic ch4_preload_enable,
	output logic ch3_fast_enable,
	output logic ch4_fast_enable,
	output tcm_pkg::tcm_filt_t ch3_input_filter,
	output tcm_pkg::tcm_filt_t ch4_input_filter,
	output tcm_pkg::tcm_psc_t ch3_input_prescaler,
	output tcm_pkg::tcm_psc_t ch4_input_prescaler,
	output logic ch3_capture_signal,
	output logic ch4_capture_signal,
	output logic ch3_capture_event,
	output logic ch4_capture_event,
	output logic ch3_fast_match,
	output logic ch4_fast_match
);
	localparam int NCH = 2;

	// Filter code to {sample divider mask, event count}
	function automatic logic [8:0] filt_cfg(input tcm_pkg::tcm_filt_t code);
		logic [8:0] r;
		r = 9'h000;
		unique case (code)
			4'h0: r = {5'h00, 4'h0};
			4'h1: r = {5'h00, 4'h2};
			4'h2: r = {5'h00, 4'h4};
			4'h3: r = {5'h00, 4'h8};
			4'h4: r = {5'h01, 4'h6};
			4'h5: r = {5'h01, 4'h8};
			4'h6: r = {5'h03, 4'h6};
			4'h7: r = {5'h03, 4'h8};
			4'h8: r = {5'h07, 4'h6};
			4'h9: r = {5'h07, 4'h8};
			4'ha: r = {5'h0f, 4'h5};
			4'hb: r = {5'h0f, 4'h6};
			4'hc: r = {5'h0f, 4'h8};
			4'hd: r = {5'h1f, 4'h5};
			4'he: r = {5'h1f, 4'h6};
			4'hf: r = {5'h1f, 4'h8};
		endcase
		return r;
	endfunction : filt_cfg

	// Configuration and register-port state
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [`TCM_DIV_BITS-1:0] div_cnt_r;

	// Pin synchronisers
	logic [NCH-1:0] ti_meta_r;
	logic [NCH-1:0] ti_sync_r;
	logic trig_prev_r;
	logic trig_rise;

	// Per-channel wiring, index 0 is channel 3 and index 1 is channel 4
	logic [NCH-1:0] enable;
	logic [NCH-1:0] is_output;
	logic [NCH-1:0] src_valid;
	logic [NCH-1:0] src_raw;
	logic [NCH-1:0] filt_level;
	logic [NCH-1:0] level_prev_r;
	logic [NCH-1:0] level_rise;
	logic [NCH-1:0] sample_en;
	logic [NCH-1:0] bypass;
	logic [NCH-1:0] capture;
	logic [NCH-1:0] fast_r;
	logic [NCH-1:0] pwm_mode;
	tcm_pkg::tcm_sel_t sel [NCH];
	tcm_pkg::tcm_sel_t sel_r [NCH];
	logic [5:0] ocv_r [NCH];
	logic [5:0] icv_r [NCH];
	logic [8:0] fcfg [NCH];

	// Register decode
	logic hit_cfg;
	logic hit_status;
	logic cfg_write;
	logic [15:0] sel_mask;
	logic [15:0] status;

	assign enable = {ch4_enable, ch3_enable};
	assign hit_cfg = reg_addr == `TCM_CFG_OFFSET;
	assign hit_status = reg_addr == `TCM_STATUS_OFFSET;
	assign cfg_write = reg_wr && hit_cfg;

	// Selection bits of an enabled channel keep their old value
	assign sel_mask = {{6{1'b0}}, {2{enable[1]}},
		{6{1'b0}}, {2{enable[0]}}};
	assign cfg_nxt = cfg_write ?
		((reg_wdata[15:0] & ~sel_mask) | (cfg_r & sel_mask)) : cfg_r;

	assign status = {{10{1'b0}}, enable, src_valid, filt_level};
	assign rdata_nxt = !reg_rd ? 32'h0000_0000 :
		hit_cfg ? {16'h0000, cfg_r} :
		hit_status ? {16'h0000, status} : 32'h0000_0000;
	assign reg_rdata = rdata_r;

	assign trig_rise = internal_trigger_signal && !trig_prev_r;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_r <= `TCM_CFG_RESET;
			rdata_r <= 32'h0000_0000;
		end else begin
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ti_meta_r <= 2'h0;
			ti_sync_r <= 2'h0;
			trig_prev_r <= 1'b0;
			div_cnt_r <= 5'h00;
		end else begin
			ti_meta_r <= {timer_input_4, timer_input_3};
			ti_sync_r <= ti_meta_r;
			trig_prev_r <= internal_trigger_signal;
			div_cnt_r <= div_cnt_r + 5'h01;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			localparam int B = i * `TCM_CH_STRIDE;

			assign sel[i] = cfg_r[B + `TCM_SEL_LSB +: 2];
			assign is_output[i] = sel[i] == `TCM_SEL_OUTPUT;
			assign fcfg[i] = filt_cfg(cfg_r[B + `TCM_FILT_LSB +: 4]);

			// Capture source mapping
			always_comb begin
				src_raw[i] = 1'b0;
				src_valid[i] = 1'b0;
				unique case (sel[i])
					`TCM_SEL_OUTPUT: begin
						src_raw[i] = 1'b0;
					end
					`TCM_SEL_OWN: begin
						src_raw[i] = ti_sync_r[i];
						src_valid[i] = 1'b1;
					end
					`TCM_SEL_OTHER: begin
						src_raw[i] = ti_sync_r[NCH-1-i];
						src_valid[i] = 1'b1;
					end
					`TCM_SEL_TRIG: begin
						src_raw[i] = trigger_source_internal &&
							internal_trigger_signal;
						src_valid[i] = trigger_source_internal;
					end
				endcase
			end

			// Sample strobe from the shared divider
			assign sample_en[i] =
				(div_cnt_r & fcfg[i][8:4]) == 5'h00;
			assign bypass[i] = (fcfg[i][3:0] == 4'h0) ||
				(sel[i] == `TCM_SEL_TRIG);

			tcm_in_filter u_filt (
				.mclk(mclk),
				.reset(reset),
				.sample_en(sample_en[i]),
				.bypass(bypass[i]),
				.count_n(fcfg[i][3:0]),
				.din(src_raw[i]),
				.dout(filt_level[i])
			);

			assign level_rise[i] = filt_level[i] && !level_prev_r[i] &&
				src_valid[i];

			tcm_in_prescaler u_psc (
				.mclk(mclk),
				.reset(reset),
				.clear(!enable[i] || is_output[i]),
				.edge_in(level_rise[i]),
				.ratio(cfg_r[B + `TCM_PSC_LSB +: 2]),
				.capture(capture[i])
			);

			assign pwm_mode[i] =
				(cfg_r[B + `TCM_MODE_LSB +: 3] == `TCM_MODE_PWM1) ||
				(cfg_r[B + `TCM_MODE_LSB +: 3] == `TCM_MODE_PWM2);

			always_ff @(posedge mclk) begin
				if (reset) begin
					level_prev_r[i] <= 1'b0;
					fast_r[i] <= 1'b0;
					sel_r[i] <= `TCM_SEL_OUTPUT;
					ocv_r[i] <= 6'h00;
					icv_r[i] <= 6'h00;
				end else begin
					level_prev_r[i] <= filt_level[i];
					// One cycle after the trigger edge
					fast_r[i] <= trig_rise && is_output[i] && pwm_mode[i] &&
						cfg_r[B + `TCM_FAST_BIT];
					sel_r[i] <= sel[i];
					// Compare view of the channel byte
					ocv_r[i] <= is_output[i] ?
						cfg_r[B + 2 +: 6] : 6'h00;
					// Capture view of the channel byte
					icv_r[i] <= is_output[i] ?
						6'h00 : cfg_r[B + 2 +: 6];
				end
			end
		end
	endgenerate

	// Channel 3 fields
	assign ch3_direction_select = sel_r[0];
	assign ch3_is_output = sel_r[0] == `TCM_SEL_OUTPUT;
	assign ch3_ref_clear_enable = ocv_r[0][`TCM_CLEAR_BIT - 2];
	assign ch3_compare_mode = ocv_r[0][`TCM_MODE_LSB - 2 +: 3];
	assign ch3_preload_enable = ocv_r[0][`TCM_PRELOAD_BIT - 2];
	assign ch3_fast_enable = ocv_r[0][`TCM_FAST_BIT - 2];
	assign ch3_input_filter = icv_r[0][`TCM_FILT_LSB - 2 +: 4];
	assign ch3_input_prescaler = icv_r[0][`TCM_PSC_LSB - 2 +: 2];
	assign ch3_capture_signal = level_prev_r[0];
	assign ch3_capture_event = capture[0];
	assign ch3_fast_match = fast_r[0];

	// Channel 4 fields
	assign ch4_direction_select = sel_r[1];
	assign ch4_is_output = sel_r[1] == `TCM_SEL_OUTPUT;
	assign ch4_ref_clear_enable = ocv_r[1][`TCM_CLEAR_BIT - 2];
	assign ch4_compare_mode = ocv_r[1][`TCM_MODE_LSB - 2 +: 3];
	assign ch4_preload_enable = ocv_r[1][`TCM_PRELOAD_BIT - 2];
	assign ch4_fast_enable = ocv_r[1][`TCM_FAST_BIT - 2];
	assign ch4_input_filter = icv_r[1][`TCM_FILT_LSB - 2 +: 4];
	assign ch4_input_prescaler = icv_r[1][`TCM_PSC_LSB - 2 +: 2];
	assign ch4_capture_signal = level_prev_r[1];
	assign ch4_capture_event = capture[1];
	assign ch4_fast_match = fast_r[1];
endmodule : tcm_mode_config

// ---- tcm_consts.svh ----
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

// Register map
`define TCM_CFG_OFFSET 8'h1c
`define TCM_STATUS_OFFSET 8'h40
`define TCM_CFG_RESET 16'h0000
`define TCM_CFG_WIDTH 16

// Channel byte layout, channel 3 in byte 0 and channel 4 in byte 1
`define TCM_CH_STRIDE 8
`define TCM_SEL_LSB 0
`define TCM_FAST_BIT 2
`define TCM_PRELOAD_BIT 3
`define TCM_MODE_LSB 4
`define TCM_CLEAR_BIT 7
`define TCM_PSC_LSB 2
`define TCM_FILT_LSB 4

// Selection codes
`define TCM_SEL_OUTPUT 2'h0
`define TCM_SEL_OWN 2'h1
`define TCM_SEL_OTHER 2'h2
`define TCM_SEL_TRIG 2'h3

// Pulse-width compare modes
`define TCM_MODE_PWM1 3'h6
`define TCM_MODE_PWM2 3'h7

// Status bit positions
`define TCM_ST_LEVEL_LSB 0
`define TCM_ST_INPUT_LSB 2
`define TCM_ST_LOCK_LSB 4

// Sampling divider width (largest ratio 32)
`define TCM_DIV_BITS 5

`endif

// ---- tcm_pkg.sv ----
package tcm_pkg;
	typedef logic [1:0] tcm_sel_t;
	typedef logic [2:0] tcm_mode_t;
	typedef logic [3:0] tcm_filt_t;
	typedef logic [1:0] tcm_psc_t;
	typedef logic [4:0] tcm_mask_t;
endpackage : tcm_pkg

// ---- tcm_in_filter.sv ----
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_in_filter (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sample_en,
	input wire logic bypass,
	input wire logic [3:0] count_n,
	input wire logic din,
	output logic dout
);
	logic [3:0] cnt_r;
	logic dout_r;
	logic differs;
	logic [3:0] cnt_inc;
	logic reached;

	assign differs = din != dout_r;
	assign cnt_inc = cnt_r + 4'h1;
	assign reached = cnt_inc >= count_n;
	assign dout = dout_r;

	// Output follows at once under bypass, else only after count_n equal samples in a row
	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_r <= 4'h0;
			dout_r <= 1'b0;
		end else if (bypass) begin
			cnt_r <= 4'h0;
			dout_r <= din;
		end else if (!differs) begin
			cnt_r <= 4'h0;
		end else if (sample_en) begin
			cnt_r <= reached ? 4'h0 : cnt_inc;
			if (reached) begin
				dout_r <= din;
			end
		end
	end
endmodule : tcm_in_filter

// ---- tcm_in_prescaler.sv ----
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_in_prescaler (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clear,
	input wire logic edge_in,
	input wire tcm_pkg::tcm_psc_t ratio,
	output logic capture
);
	logic [2:0] cnt_r;
	logic capture_r;
	logic [2:0] mask;
	logic last;

	// Ratio code k captures once every 2**k events
	assign mask = 3'((4'h1 << ratio) - 4'h1);
	assign last = (cnt_r & mask) == mask;
	assign capture = capture_r;

	always_ff @(posedge mclk) begin
		if (reset || clear) begin
			cnt_r <= 3'h0;
			capture_r <= 1'b0;
		end else begin
			capture_r <= edge_in && last;
			if (edge_in) begin
				cnt_r <= last ? 3'h0 : cnt_r + 3'h1;
			end
		end
	end
endmodule : tcm_in_prescaler

// ---- tcm_mode_config_sva.sv ----
`timescale 1ns/1ps
module tcm_mode_config_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic internal_trigger_signal,
	input wire logic ch3_enable,
	input wire logic ch4_enable,
	input wire tcm_pkg::tcm_sel_t ch3_direction_select,
	input wire tcm_pkg::tcm_sel_t ch4_direction_select,
	input wire logic ch4_is_output,
	input wire logic ch4_fast_enable,
	input wire tcm_pkg::tcm_mode_t ch4_compare_mode,
	input wire tcm_pkg::tcm_filt_t ch4_input_filter,
	input wire tcm_pkg::tcm_psc_t ch4_input_prescaler,
	input wire logic ch4_capture_event,
	input wire logic ch4_fast_match
);
	wire logic wr_cfg = reg_wr && reg_addr == 8'h1c;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	a_ch3_sel_write: assert property (wr_cfg && !ch3_enable
		|-> ##2 ch3_direction_select == $past(reg_wdata[1:0], 2))
		else $error("ch3 selection not taken");
	a_ch3_sel_locked: assert property (wr_cfg && ch3_enable
		|-> ##2 $stable(ch3_direction_select))
		else $error("ch3 selection changed while enabled");
	a_ch4_sel_write: assert property (wr_cfg && !ch4_enable
		|-> ##2 ch4_direction_select == $past(reg_wdata[9:8], 2))
		else $error("ch4 selection not taken");
	a_ch4_sel_locked: assert property (wr_cfg && ch4_enable
		|-> ##2 $stable(ch4_direction_select))
		else $error("ch4 selection changed while enabled");
	a_ch4_is_output: assert property (wr_cfg && !ch4_enable
		|-> ##2 ch4_is_output == ($past(reg_wdata[9:8], 2) == 2'h0))
		else $error("ch4 direction flag wrong");
	a_ch4_capture_fields: assert property (wr_cfg && !ch4_enable
		&& reg_wdata[9:8] != 2'h0 |-> ##2 {ch4_input_filter,
		ch4_input_prescaler} == $past(reg_wdata[15:10], 2))
		else $error("ch4 capture fields wrong");
	a_ch4_fast_match: assert property ($rose(internal_trigger_signal)
		&& ch4_is_output && ch4_fast_enable && ch4_compare_mode[2:1] == 2'h3
		|-> ##[1:3] ch4_fast_match)
		else $error("ch4 fast match missing");
	a_ch4_event_off: assert property (!ch4_enable [*3]
		|-> !ch4_capture_event)
		else $error("ch4 capture while disabled");
	c_locked: cover property (wr_cfg && ch4_enable);
	c_event: cover property (ch4_capture_event);
	c_fast: cover property (ch4_fast_match);
endmodule : tcm_mode_config_chk

bind tcm_mode_config tcm_mode_config_chk i_chk (.mclk, .reset, .reg_addr,
	.reg_wdata, .reg_wr, .internal_trigger_signal, .ch3_enable, .ch4_enable,
	.ch3_direction_select, .ch4_direction_select, .ch4_is_output,
	.ch4_fast_enable, .ch4_compare_mode, .ch4_input_filter,
	.ch4_input_prescaler, .ch4_capture_event, .ch4_fast_match);

// ---- test_tcm_mode_config.sv ----
`timescale 1ns/1ps
module test_tcm_mode_config;
	logic mclk, reset, reg_wr, reg_rd, trigger_source_internal;
	logic ch3_enable, ch4_enable;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [2:0] pins;
	tcm_pkg::tcm_sel_t ch3_direction_select, ch4_direction_select;
	logic ch3_is_output, ch4_is_output, ch3_ref_clear_enable;
	logic ch4_ref_clear_enable, ch3_preload_enable, ch4_preload_enable;
	logic ch3_fast_enable, ch4_fast_enable;
	tcm_pkg::tcm_mode_t ch3_compare_mode, ch4_compare_mode;
	tcm_pkg::tcm_filt_t ch3_input_filter, ch4_input_filter;
	tcm_pkg::tcm_psc_t ch3_input_prescaler, ch4_input_prescaler;
	logic ch3_capture_event, ch4_capture_event, ch4_fast_match;
	logic ch3_capture_signal, ch4_capture_signal, ch3_fast_match;
	int err_total, n_tests, n3, n4, nf, nh;

	tcm_mode_config i_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .timer_input_3(pins[0]), .timer_input_4(pins[1]),
		.internal_trigger_signal(pins[2]), .trigger_source_internal,
		.ch3_enable, .ch4_enable, .ch3_direction_select, .ch4_direction_select,
		.ch3_is_output, .ch4_is_output, .ch3_ref_clear_enable,
		.ch4_ref_clear_enable, .ch3_compare_mode, .ch4_compare_mode,
		.ch3_preload_enable, .ch4_preload_enable, .ch3_fast_enable,
		.ch4_fast_enable, .ch3_input_filter, .ch4_input_filter,
		.ch3_input_prescaler, .ch4_input_prescaler, .ch3_capture_signal,
		.ch4_capture_signal, .ch3_capture_event, .ch4_capture_event,
		.ch3_fast_match, .ch4_fast_match);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(negedge mclk) begin
		if (ch3_capture_event === 1'b1) n3++;
		if (ch4_capture_event === 1'b1) n4++;
		if (ch4_fast_match === 1'b1) nf++;
		if (ch3_fast_match === 1'b1) nf++;
		if (ch3_capture_signal === 1'b1) nh++;
		if (ch4_capture_signal === 1'b1) nh++;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task set_en(input logic e3, input logic e4);
		@(posedge mclk);
		ch3_enable <= e3;
		ch4_enable <= e4;
	endtask : set_en

	// Pulses one source n times and counts what comes out
	task pulse(input int w, input int n);
		n3 = 0;
		n4 = 0;
		nf = 0;
		nh = 0;
		repeat (3) @(posedge mclk);
		repeat (n) begin
			pins <= 3'h1 << w;
			repeat (4) @(posedge mclk);
			pins <= 3'h0;
			repeat (4) @(posedge mclk);
		end
		repeat (8) @(posedge mclk);
	endtask : pulse

	task complete_run;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run

	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		pins = 3'h0;
		trigger_source_internal = 1'b1;
		ch3_enable = 1'b0;
		ch4_enable = 1'b0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		rd(8'h1c);
		chk(d, 32'h0);
		wr(8'h1c, 32'hffff_b9d4);
		rd(8'h1c);
		chk(d, 32'h0000_b9d4);
		@(negedge mclk);
		chk(32'({ch3_is_output, ch3_ref_clear_enable, ch3_compare_mode,
			ch3_preload_enable, ch3_fast_enable, ch3_input_filter,
			ch3_input_prescaler}), 32'h1d40);
		chk(32'({ch4_is_output, ch4_direction_select, ch4_input_filter,
			ch4_input_prescaler, ch4_ref_clear_enable, ch4_compare_mode,
			ch4_preload_enable, ch4_fast_enable}), 32'h1b80);
		set_en(1'b1, 1'b1);
		wr(8'h1c, 32'h4a07);
		rd(8'h1c);
		chk(d, 32'h4904);
		wr(8'h30, 32'hffff);
		rd(8'h30);
		chk(d, 32'h0);
		rd(8'h1c);
		chk(d, 32'h4904);
		for (int s = 1; s < 4; s++) begin
			for (int w = 0; w < 3; w++) begin
				set_en(1'b0, 1'b0);
				wr(8'h1c, 32'(s * 257));
				set_en(1'b1, 1'b1);
				pulse(w, 1);
				chk(32'(n3), 32'(w == s - 1));
				chk(32'(n4), 32'(w == ((s == 3) ? 2 : 2 - s)));
				chk(32'(nh), 32'(4 * ((w == s - 1) +
					(w == ((s == 3) ? 2 : 2 - s)))));
			end
		end
		trigger_source_internal <= 1'b0;
		pulse(2, 1);
		chk(32'(n3 + n4 + nh), 32'h0);
		trigger_source_internal <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			set_en(1'b0, 1'b0);
			wr(8'h1c, 32'(p * 1024 + 256));
			set_en(1'b0, 1'b1);
			rd(8'h40);
			chk(d, 32'h0000_0028);
			pulse(1, 8);
			chk(32'(n4), 32'(8 >> p));
		end
		set_en(1'b0, 1'b0);
		pulse(1, 8);
		chk(32'(n4), 32'h0);
		// Four-cycle pulses pass a two-sample filter, not an eight-sample one
		for (int f = 1; f < 4; f += 2) begin
			set_en(1'b0, 1'b0);
			wr(8'h1c, 32'(f * 4096 + 256));
			set_en(1'b0, 1'b1);
			pulse(1, 1);
			chk(32'(n4), 32'(f == 1));
		end
		set_en(1'b0, 1'b0);
		for (int m = 0; m < 8; m++) begin
			wr(8'h1c, 32'(m * 4112 + 1028));
			pulse(2, 1);
			chk(32'(nf), 32'(2 * (m > 5)));
		end
		// Reset in mid-run clears the register and the field outputs
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		rd(8'h1c);
		chk(d, 32'h0);
		chk(32'({ch4_is_output, ch4_compare_mode, ch4_fast_enable}),
			32'h10);
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		complete_run;
	end
endmodule : test_tcm_mode_config
